// File: wdt_defines.svh
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================================
// Register offsets
`define WDT_CTRL_ADDR 8'h8F
`define WDT_STAT_ADDR 8'hA0
`define WDT_MASK_ADDR 8'hA1
`define WDT_CNT_LO_ADDR 8'hA2
`define WDT_CNT_HI_ADDR 8'hA3

// ==========================================================
// Control register fields
`define WDT_EN_BIT 7
`define WDT_CLR_BIT 6
`define WDT_IDLE_RUN_BIT 5
`define WDT_PS_MSB 2
`define WDT_PS_LSB 0

// ==========================================================
// Status and mask register fields
`define WDT_EV_TIMEOUT_BIT 0
`define WDT_EV_CLEARED_BIT 1
`define WDT_EV_WIDTH 2

// ==========================================================
// Reset values
`define WDT_CTRL_RESET 8'h00
`define WDT_EV_RESET 2'h0
`define WDT_RDATA_RESET 8'h00

// ==========================================================
// Timing
`define WDT_CLK_PERIOD_NS 100
`define WDT_CLKS_PER_COUNT 12
`define WDT_TIMER_BITS 14
`define WDT_TIMEOUT_TICKS 16384
`define WDT_RESET_HOLD_NS 2400
`define WDT_RESET_HOLD_CYCLES ((`WDT_RESET_HOLD_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)

`endif

// File: wdt_pkg.sv
// Types shared by the watchdog modules
package wdt_pkg;

  // ==========================================================
  // Watchdog sequencing states, Gray along off, run, hold
  typedef enum logic [1:0] {
    WDT_ST_OFF = 2'b00,
    WDT_ST_RUN = 2'b01,
    WDT_ST_HOLD = 2'b11
  } wdt_state_t;

  // Prescaler select code
  typedef logic [2:0] wdt_ps_sel_t;

  // Timer count value
  typedef logic [13:0] wdt_count_t;

endpackage : wdt_pkg

// File: wdt_prescaler.sv
// Machine-cycle divider and selectable prescaler of the watchdog
`timescale 1ns/1ns
`include "wdt_defines.svh"
module wdt_prescaler
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  input wire logic run,
  input wire wdt_ps_sel_t ps_sel,
  output logic count_tick
);

  // ==========================================================
  // Select decode
  function automatic logic [8:0] wdt_divisor(input wdt_ps_sel_t sel);
    logic [8:0] d;
    d = 9'h002;
    unique case (sel)
      3'h0: d = 9'h002;
      3'h2: d = 9'h004;
      3'h1: d = 9'h008;
      3'h3: d = 9'h010;
      3'h4: d = 9'h020;
      3'h5: d = 9'h040;
      3'h6: d = 9'h080;
      3'h7: d = 9'h100;
    endcase
    return d;
  endfunction : wdt_divisor

  logic [3:0] mc_cnt_reg;
  logic [3:0] mc_cnt_next;
  logic [7:0] div_cnt_reg;
  logic [7:0] div_cnt_next;
  logic mc_end;
  logic div_end;

  // ==========================================================
  // Next values: twelve clocks per count, then divide by the select
  always_comb begin
    mc_end = (mc_cnt_reg == 4'(`WDT_CLKS_PER_COUNT - 1));
    div_end = ({1'b0, div_cnt_reg} == (wdt_divisor(ps_sel) - 9'h001));
    count_tick = run && mc_end && div_end;
    mc_cnt_next = mc_cnt_reg;
    div_cnt_next = div_cnt_reg;
    if (clear) begin
      mc_cnt_next = 4'h0;
      div_cnt_next = 8'h00;
    end else if (run) begin
      mc_cnt_next = mc_end ? 4'h0 : mc_cnt_reg + 4'h1;
      if (mc_end) begin
        div_cnt_next = div_end ? 8'h00 : div_cnt_reg + 8'h01;
      end
    end
  end

  // Registers, frozen while ce is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mc_cnt_reg <= 4'h0;
      div_cnt_reg <= 8'h00;
    end else if (ce) begin
      mc_cnt_reg <= mc_cnt_next;
      div_cnt_reg <= div_cnt_next;
    end
  end

endmodule : wdt_prescaler

// File: wdt_tb.sv
// Self-checking bench for the watchdog top
`timescale 1ns/1ns
`include "wdt_defines.svh"
module tb;
  // ==========
  // Signals
  localparam int TT = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic idle_request = 1'b0;
  logic [7:0] rdata;
  logic wd_reset;
  logic irq;
  int fail_count = 0;
  int total_checks = 0;
  int dv[8] = '{2, 8, 4, 16, 32, 64, 128, 256};

  // Short count so a time-out takes 96 clocks at the fastest tap
  wdt_top #(.TIMEOUT_TICKS(TT)) u_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .idle_request(idle_request), .wd_reset(wd_reset), .irq(irq)
  );

  // 100 ns clock
  always #50 clk = ~clk;

  // ==========
  // Tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask : rd_chk

  // Watch for any reset request over a span
  task automatic quiet(input int n, input string nm);
    int h;
    h = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (wd_reset !== 1'b0) h++;
    end
    chk(nm, 8'h00, {7'h00, h != 0});
  endtask : quiet

  // Enable with clear, time the reset request, then wait for its end
  task automatic tmo(input string nm, input logic [7:0] c, input int e);
    int n;
    n = 0;
    wr_reg(`WDT_CTRL_ADDR, c);
    while (wd_reset !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(nm, 8'h01, 8'(n >= e - 1 && n <= e + 4));
    n = 0;
    while (wd_reset !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("reset pulse length", 8'(`WDT_RESET_HOLD_CYCLES), 8'(n));
    rd_chk("ctrl after reset pulse", `WDT_CTRL_ADDR, 8'h00);
  endtask : tmo

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // ==========
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk("ctrl reset", `WDT_CTRL_ADDR, 8'h00);
    quiet(200, "reset while off");
    rd_chk("status timeout", `WDT_STAT_ADDR, 8'h01);
    done("reset");
    wr_reg(`WDT_CTRL_ADDR, 8'h18);
    rd_chk("ctrl unused", `WDT_CTRL_ADDR, 8'h00);
    wr_reg(`WDT_CTRL_ADDR, 8'h7F);
    rd_chk("ctrl self clear", `WDT_CTRL_ADDR, 8'h27);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr_reg(`WDT_CTRL_ADDR, 8'h40);
    quiet(300, "disabled long");
    done("control");
    chk("irq masked", 8'h00, {7'h00, irq});
    wr_reg(`WDT_MASK_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("irq raised", 8'h01, {7'h00, irq});
    wr_reg(`WDT_CTRL_ADDR, 8'h40);
    rd_chk("count cleared", `WDT_CNT_LO_ADDR, 8'h00);
    wr_reg(`WDT_STAT_ADDR, 8'h03);
    repeat (2) @(posedge clk);
    #1;
    chk("irq cleared", 8'h00, {7'h00, irq});
    done("irq");
    repeat (5) begin
      wr_reg(`WDT_CTRL_ADDR, 8'hC0);
      quiet(60, "kicked in time");
    end
    done("kick");
    @(posedge clk);
    idle_request <= 1'b1;
    wr_reg(`WDT_CTRL_ADDR, 8'hC0);
    quiet(300, "idle stopped");
    tmo("idle running", 8'hE0, 12 * 2 * TT);
    @(posedge clk);
    idle_request <= 1'b0;
    done("idle");
    for (int i = 0; i < 8; i++) begin
      tmo("prescale period", 8'hC0 | 8'(i), 12 * dv[i] * TT);
    end
    done("prescale");
    // Clock enable low freezes the count, then a mid-run device reset clears it
    wr_reg(`WDT_CTRL_ADDR, 8'h40);
    @(posedge clk);
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    repeat (50) @(posedge clk);
    rd_chk("count frozen", `WDT_CNT_LO_ADDR, 8'h02);
    wr_reg(`WDT_CTRL_ADDR, 8'h27);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rd_chk("count after reset", `WDT_CNT_LO_ADDR, 8'h00);
    rd_chk("count high after reset", `WDT_CNT_HI_ADDR, 8'h00);
    rd_chk("ctrl after device reset", `WDT_CTRL_ADDR, 8'h00);
    done("freeze and reset");
    stop_test();
  end

  // Hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule : tb

// File: wdt_timer.sv
// Fourteen-bit watchdog timer with expiry detect
`timescale 1ns/1ns
`include "wdt_defines.svh"
module wdt_timer
  import wdt_pkg::*;
#(
  parameter int TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  input wire logic tick,
  output wdt_count_t count,
  output logic expire
);

  wdt_count_t count_reg;
  wdt_count_t count_next;

  // ==========================================================
  // Next count: wraps after the last tick of the interval
  always_comb begin
    expire = tick && (count_reg == 14'(TIMEOUT_TICKS - 1));
    count_next = count_reg;
    if (clear) begin
      count_next = 14'h0000;
    end else if (expire) begin
      count_next = 14'h0000;
    end else if (tick) begin
      count_next = count_reg + 14'h0001;
    end
  end

  // Count register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 14'h0000;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule : wdt_timer

// File: wdt_top.sv
// Watchdog timer unit: control register, sequencing, interrupt and reset request
//
// What this block does
// - The watchdog counts freely through a clock divider chain whose selected tap sets the interval.
// - A time-out while the watchdog is enabled raises the system reset request.
// - After device reset the watchdog is disabled and cannot raise a reset until software enables it.
// - Control bit 7 is the enable, and setting it arms the time-out reset; the count runs whether it is set or not.
// - Writing one to control bit 6 clears timer and prescaler, and hardware returns the bit to zero.
// - The clear of timer, prescaler and the clear bit happens on the cycle after the write.
// - Control bit 5 lets the watchdog run in idle mode when one and stops it there when zero.
// - Select codes 000,010,001,011,100,101,110,111 give division by 2,4,8,16,32,64,128,256.
// - The interval is 2 to the 14 counts, each of prescaler times twelve clocks.
// - Device reset clears the watchdog count to zero.
// - Idle mode stops only the processor, so the watchdog can keep counting in idle.
// - Device reset loads the control register with all zeros.
`timescale 1ns/1ns
`include "wdt_defines.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter int TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic idle_request,
  output logic wd_reset,
  output logic irq
);

  // ==========================================================
  // Control register state
  logic wd_enable_reg;
  logic wd_enable_next;
  logic wd_clear_request_reg;
  logic wd_clear_request_next;
  logic wd_idle_run_reg;
  logic wd_idle_run_next;
  wdt_ps_sel_t ps_sel_reg;
  wdt_ps_sel_t ps_sel_next;

  // ==========================================================
  // Event, mask and read-back state
  logic [`WDT_EV_WIDTH-1:0] status_reg;
  logic [`WDT_EV_WIDTH-1:0] status_next;
  logic [`WDT_EV_WIDTH-1:0] mask_reg;
  logic [`WDT_EV_WIDTH-1:0] mask_next;
  logic [`WDT_EV_WIDTH-1:0] events;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;

  // ==========================================================
  // Sequencer state
  wdt_state_t state_reg;
  wdt_state_t state_next;
  logic [7:0] hold_cnt_reg;
  logic [7:0] hold_cnt_next;
  logic wd_reset_reg;
  logic wd_reset_next;

  // ==========================================================
  // Datapath links
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic counting;
  logic chain_clear;
  logic hold_done;
  logic count_tick;
  logic expire;
  wdt_count_t count;

  // Register write decodes
  assign wr_ctrl = wr && (addr == `WDT_CTRL_ADDR);
  assign wr_stat = wr && (addr == `WDT_STAT_ADDR);
  assign wr_mask = wr && (addr == `WDT_MASK_ADDR);

  assign counting = !idle_request || wd_idle_run_reg;

  assign chain_clear = wd_clear_request_reg || hold_done;

  assign hold_done = (state_reg == WDT_ST_HOLD) &&
                     (hold_cnt_reg == 8'(`WDT_RESET_HOLD_CYCLES - 1));

  // ==========================================================
  // Divider chain
  // selectable divider tap
  wdt_prescaler u_prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(chain_clear),
    .run(counting),
    .ps_sel(ps_sel_reg),
    .count_tick(count_tick)
  );

  wdt_timer #(
    .TIMEOUT_TICKS(TIMEOUT_TICKS)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(chain_clear),
    .tick(count_tick),
    .count(count),
    .expire(expire)
  );

  // ==========================================================
  // Control register next values
  always_comb begin
    wd_enable_next = wd_enable_reg;
    wd_idle_run_next = wd_idle_run_reg;
    ps_sel_next = ps_sel_reg;
    wd_clear_request_next = 1'b0;
    if (wr_ctrl) begin
      wd_enable_next = wdata[`WDT_EN_BIT];
      wd_idle_run_next = wdata[`WDT_IDLE_RUN_BIT];
      ps_sel_next = wdata[`WDT_PS_MSB:`WDT_PS_LSB];
      wd_clear_request_next = wdata[`WDT_CLR_BIT];
    end
    if (hold_done) begin
      wd_enable_next = 1'b0;
      wd_idle_run_next = 1'b0;
      ps_sel_next = 3'h0;
      wd_clear_request_next = 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_enable_reg <= 1'(`WDT_CTRL_RESET >> `WDT_EN_BIT);
      wd_clear_request_reg <= 1'b0;
      wd_idle_run_reg <= 1'b0;
      ps_sel_reg <= 3'h0;
    end else if (ce) begin
      wd_enable_reg <= wd_enable_next;
      wd_clear_request_reg <= wd_clear_request_next;
      wd_idle_run_reg <= wd_idle_run_next;
      ps_sel_reg <= ps_sel_next;
    end
  end

  // ==========================================================
  // Sequencer next values
  always_comb begin
    state_next = state_reg;
    hold_cnt_next = 8'h00;
    wd_reset_next = 1'b0;
    unique case (state_reg)
      WDT_ST_OFF: begin
        // a time-out in the arming cycle still resets
        if (wd_enable_reg && expire) begin
          state_next = WDT_ST_HOLD;
          wd_reset_next = 1'b1;
        end else if (wd_enable_reg) begin
          state_next = WDT_ST_RUN;
        end
      end
      WDT_ST_RUN: begin
        if (!wd_enable_next) begin
          state_next = WDT_ST_OFF;
        end else if (expire && wd_enable_reg) begin
          state_next = WDT_ST_HOLD;
          wd_reset_next = 1'b1;
        end
      end
      WDT_ST_HOLD: begin
        wd_reset_next = !hold_done;
        hold_cnt_next = hold_cnt_reg + 8'h01;
        if (hold_done) begin
          state_next = WDT_ST_OFF;
          hold_cnt_next = 8'h00;
        end
      end
      default: begin
        state_next = WDT_ST_OFF;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= WDT_ST_OFF;
      hold_cnt_reg <= 8'h00;
      wd_reset_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      wd_reset_reg <= wd_reset_next;
    end
  end

  // ==========================================================
  // Events, mask and interrupt next values
  always_comb begin
    events = `WDT_EV_RESET;
    events[`WDT_EV_TIMEOUT_BIT] = expire;
    events[`WDT_EV_CLEARED_BIT] = wd_clear_request_reg;
    status_next = status_reg;
    if (wr_stat) begin
      status_next = status_reg & ~wdata[`WDT_EV_WIDTH-1:0];
    end
    // A new event wins over a same-cycle clear
    status_next = status_next | events;
    mask_next = wr_mask ? wdata[`WDT_EV_WIDTH-1:0] : mask_reg;
    irq_next = |(status_next & mask_next);
  end

  // Event registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= `WDT_EV_RESET;
      mask_reg <= `WDT_EV_RESET;
      irq_reg <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  // ==========================================================
  // Read data next value, zero outside a read and for unmapped offsets
  always_comb begin
    rdata_next = `WDT_RDATA_RESET;
    if (rd) begin
      unique case (addr)
        `WDT_CTRL_ADDR: begin
          rdata_next[`WDT_EN_BIT] = wd_enable_reg;
          rdata_next[`WDT_CLR_BIT] = wd_clear_request_reg;
          rdata_next[`WDT_IDLE_RUN_BIT] = wd_idle_run_reg;
          rdata_next[`WDT_PS_MSB:`WDT_PS_LSB] = ps_sel_reg;
        end
        `WDT_STAT_ADDR: begin
          rdata_next[`WDT_EV_WIDTH-1:0] = status_reg;
        end
        `WDT_MASK_ADDR: begin
          rdata_next[`WDT_EV_WIDTH-1:0] = mask_reg;
        end
        `WDT_CNT_LO_ADDR: begin
          rdata_next = count[7:0];
        end
        `WDT_CNT_HI_ADDR: begin
          rdata_next = {2'h0, count[13:8]};
        end
        default: begin
          rdata_next = `WDT_RDATA_RESET;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= `WDT_RDATA_RESET;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign rdata = rdata_reg;
  assign wd_reset = wd_reset_reg;
  assign irq = irq_reg;

endmodule : wdt_top

// File: wdt_top_chk.sv
// Port level assertions for the watchdog top
`timescale 1ns/1ns
`include "wdt_defines.svh"
module wdt_top_chk
  import wdt_pkg::*;
#(
  parameter int TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic idle_request,
  input wire logic wd_reset,
  input wire logic irq
);
  // ==========
  // Helper state
  logic [5:0] hold_reg;
  logic en_reg;
  logic msk_reg;

  // Reset pulse length, enable shadow and mask shadow
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_reg <= 6'h00;
      en_reg <= 1'b0;
      msk_reg <= 1'b0;
    end else begin
      hold_reg <= wd_reset ? hold_reg + 6'h01 : 6'h00;
      if (wr && ce && addr == `WDT_CTRL_ADDR) begin
        en_reg <= wdata[`WDT_EN_BIT];
      end else if ($fell(wd_reset)) begin
        en_reg <= 1'b0;
      end
      if (wr && ce && addr == `WDT_MASK_ADDR) begin
        msk_reg <= wdata[0];
      end
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Clear write, then a read two cycles on
  sequence s_clr_wr;
    wr && addr == `WDT_CTRL_ADDR && wdata[`WDT_CLR_BIT];
  endsequence
  sequence s_rd_at(a);
    !wr ##1 rd && addr == a;
  endsequence

  AST_RST_CLEAN: assert property ($rose(rst_b) |-> !wd_reset && !irq && rdata == 8'h00)
    else $error("outputs not idle after reset");
  AST_CTRL_RSVD: assert property (rd && addr == `WDT_CTRL_ADDR |=> rdata[4:3] == 2'b00)
    else $error("unused control bits read nonzero");
  AST_CLR_SELF: assert property (s_clr_wr ##1 s_rd_at(`WDT_CTRL_ADDR) |=> !rdata[6])
    else $error("clear bit still set");
  AST_CNT_CLR: assert property (s_clr_wr ##1 s_rd_at(`WDT_CNT_LO_ADDR) |=> rdata == 8'h00)
    else $error("count not cleared");
  AST_DIS_NORST: assert property (!en_reg && !wd_reset |=> !wd_reset)
    else $error("reset raised while disabled");
  AST_HOLD_LEN: assert property ($fell(wd_reset) |-> hold_reg == 6'h18)
    else $error("reset pulse length wrong");
  AST_HOLD_MAX: assert property (hold_reg <= 6'h18)
    else $error("reset pulse too long");
  AST_IRQ_MASK: assert property ($rose(wd_reset) && msk_reg |-> irq)
    else $error("time-out interrupt missing");
endmodule : wdt_top_chk

bind wdt_top wdt_top_chk #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) u_chk (
  .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .idle_request(idle_request), .wd_reset(wd_reset), .irq(irq)
);
